// >>> core/dcfs_pkg.sv
// Shared constants and types for the dual channel fault supervisor
package dcfs_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_NS = 10;
  localparam int UV_FILT_NS = 1500;
  localparam int UV_CYC = (UV_FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int OC_TICKS = 8;
  localparam int FRAME_NS = 36000;
  localparam int FRAME_CYC = FRAME_NS / CLK_NS;
  localparam int FRAME_SLOTS = 9;
  localparam int SLOT_CYC = FRAME_CYC / FRAME_SLOTS;
  localparam int HICCUP_CYC_DEF = 100000;
  localparam logic FAULT_IDLE = 1'b0;
  localparam logic FAULT_ALERT_LVL = 1'b1;

  // ==========================================================================
  // Register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int CTRL_EN_LSB = 0;

  // ==========================================================================
  // Fault flag positions within one channel
  localparam int FL_UV = 0;
  localparam int FL_OC = 1;
  localparam int FL_OT = 2;
  localparam int FL_DIE = 3;
  localparam int FL_W = 4;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    CH_OFF = 4'h1,
    CH_START = 4'h2,
    CH_RUN = 4'h4,
    CH_HICCUP = 4'h8
  } dcfs_ch_state_t;

  typedef struct packed {
    logic [1:0] en;
    logic supply_ok;
    logic [1:0] uv;
    logic [1:0] oc;
    logic [1:0] ot_pin;
    logic [1:0] ot_ext;
    logic [1:0] ot_cool;
    logic die_hot;
    logic die_cool;
    logic [1:0] ot_cfg;
    logic track_n;
  } dcfs_pins_t;

endpackage : dcfs_pkg

// >>> core/dcfs_supervisor.sv
// Fault supervisor for a two channel buck controller: protection, hiccup, fault frame
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module dcfs_supervisor
  import dcfs_pkg::*;
#(
  parameter int unsigned HICCUP_CYC = HICCUP_CYC_DEF
) (
  input wire logic mclk, // 100 MHz clock
  input wire logic sys_rst, // Async reset, active high
  input wire dcfs_pins_t pins, // Comparator and pin levels, asynchronous
  input wire logic sw_tick, // One pulse per switching cycle
  input wire logic two_phase, // Both phases belong to channel 0
  input wire logic [1:0] ss_begun, // Soft start has begun, per channel
  input wire logic [1:0] pgd_done, // Power good delay expired, per channel
  input wire logic [3:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  output logic [1:0] power_good_out, // Power good per channel
  output logic [1:0] switch_off, // Both switches off per channel
  output logic [1:0] phase_cut, // Cycle current limit per phase
  output logic [1:0] restart_seq, // Pulse: rerun power-up sequence
  output logic pwm_hiz, // All pulse outputs high impedance
  output logic fault_out // Serial fault frame
);

  // ==========================================================================
  // Input synchroniser
  dcfs_pins_t sync1_q;
  dcfs_pins_t sy_q;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_q <= '0;
      sy_q <= '0;
    end
    else
    begin
      sync1_q <= pins;
      sy_q <= sync1_q;
    end
  end

  // ==========================================================================
  // Register port
  logic [1:0] ctrl_q;
  logic [31:0] rdata_q;
  logic [1:0] pg_q;
  logic tsd_q;
  logic frame_q;
  logic [FL_W-1:0] flags [2];
  dcfs_ch_state_t st_vec [2];

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_q <= CTRL_RST;
    else if (reg_wr && reg_addr == REG_CTRL)
      ctrl_q <= reg_wdata[CTRL_EN_LSB +: 2];
  end

  // Unmapped addresses read as zero; data stands for one cycle only
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= '0;
    else if (reg_rd && reg_addr == REG_CTRL)
      rdata_q <= {30'h0, ctrl_q};
    else if (reg_rd && reg_addr == REG_STATUS)
      rdata_q <= {12'h0, st_vec[1], st_vec[0], flags[1], flags[0],
        tsd_q, frame_q, pg_q};
    else
      rdata_q <= '0;
  end

  assign reg_rdata = rdata_q;

  // ==========================================================================
  // Die thermal shutdown
  logic die_arm;
  logic tsd_set;

  assign die_arm = sy_q.supply_ok & (|sy_q.en);
  assign tsd_set = die_arm & sy_q.die_hot & ~tsd_q;

  // Hysteresis between the two die comparators keeps this from chattering
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      tsd_q <= 1'b0;
    else if (tsd_set)
      tsd_q <= 1'b1;
    else if (tsd_q && sy_q.die_cool)
      tsd_q <= 1'b0;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      pwm_hiz <= 1'b0;
    else
      pwm_hiz <= tsd_q;
  end

  // ==========================================================================
  // Phase ownership and tracking mode
  function automatic logic [1:0] phase_mask(input logic tp, input int ch);
    if (tp)
      phase_mask = (ch == 0) ? 2'h3 : 2'h0;
    else
      phase_mask = (ch == 0) ? 2'h1 : 2'h2;
  endfunction : phase_mask

  logic track_q;
  logic [1:0] trip;
  logic [1:0] hic_go;
  logic frame_clr;

  // Mode pin is only trusted while both channels are stopped
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      track_q <= 1'b0;
    else if (st_vec[0] == CH_OFF && st_vec[1] == CH_OFF)
      track_q <= ~sy_q.track_n;
  end

  assign hic_go = trip | {2{track_q & (|trip)}};

  // Cycle by cycle limit: latched in the cycle, freed at the next tick
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      phase_cut <= '0;
    else if (sw_tick)
      phase_cut <= '0;
    else
      phase_cut <= phase_cut | sy_q.oc;
  end

  // ==========================================================================
  // Per channel protection
  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_ch
      dcfs_ch_state_t st_q;
      logic [7:0] uv_cnt_q;
      logic [3:0] oc_cnt_q;
      logic [31:0] hic_cnt_q;
      logic ot_cause_q;
      logic ot_cfg_q;
      logic [FL_W-1:0] fl_q;
      logic allowed;
      logic uv_arm;
      logic ot_arm;
      logic oc_arm;
      logic oc_all;
      logic uv_trip;
      logic oc_trip;
      logic ot_trip;
      logic hic_end;
      logic [1:0] mask;
      logic [FL_W-1:0] fl_set;

      assign mask = phase_mask(two_phase, c);
      // A hot die blocks the start already in the cycle it is seen
      assign allowed = sy_q.en[c] & ctrl_q[c] & sy_q.supply_ok & ~tsd_q & ~tsd_set;
      assign uv_arm = (st_q == CH_RUN) & pgd_done[c];
      assign oc_arm = (st_q == CH_RUN) & ss_begun[c];
      assign ot_arm = (st_q == CH_RUN) & ss_begun[c];
      assign oc_all = (|mask) & (&(sy_q.oc | ~mask));
      assign uv_trip = uv_arm & sy_q.uv[c] & (uv_cnt_q == 8'(UV_CYC));
      assign oc_trip = oc_arm & oc_all & sw_tick & (oc_cnt_q == 4'(OC_TICKS));
      assign ot_trip = ot_arm & (ot_cfg_q ? sy_q.ot_ext[c] : sy_q.ot_pin[c]);
      assign trip[c] = uv_trip | oc_trip | ot_trip;
      assign hic_end = (hic_cnt_q == 32'(HICCUP_CYC - 1));
      assign st_vec[c] = st_q;
      assign flags[c] = fl_q;

      always_ff @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
          uv_cnt_q <= '0;
        else if (!(uv_arm && sy_q.uv[c]))
          uv_cnt_q <= '0;
        else if (uv_cnt_q != 8'(UV_CYC))
          uv_cnt_q <= uv_cnt_q + 8'h1;
      end

      // Counts switching cycles with every owned phase in limit
      always_ff @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
          oc_cnt_q <= '0;
        else if (!(oc_arm && oc_all))
          oc_cnt_q <= '0;
        else if (sw_tick && oc_cnt_q != 4'(OC_TICKS))
          oc_cnt_q <= oc_cnt_q + 4'h1;
      end

      // Temperature mode may only change before the channel starts
      always_ff @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
          ot_cfg_q <= 1'b0;
        else if (st_q == CH_OFF)
          ot_cfg_q <= sy_q.ot_cfg[c];
      end

      always_ff @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
          ot_cause_q <= 1'b0;
        else if (st_q == CH_RUN && hic_go[c])
          ot_cause_q <= ot_trip;
      end

      always_ff @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
          hic_cnt_q <= '0;
        else if (st_q != CH_HICCUP)
          hic_cnt_q <= '0;
        else if (!hic_end)
          hic_cnt_q <= hic_cnt_q + 32'h1;
      end

      always_ff @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
          st_q <= CH_OFF;
        else if (!allowed)
          st_q <= CH_OFF;
        else
        begin
          unique case (st_q)
            CH_OFF:
              st_q <= CH_START;
            CH_START:
              st_q <= CH_RUN;
            CH_RUN:
              if (hic_go[c])
                st_q <= CH_HICCUP;
            CH_HICCUP:
              if (hic_end && (!ot_cause_q || sy_q.ot_cool[c]))
                st_q <= CH_START;
          endcase
        end
      end

      // Event bits land at the flag positions the status word shows
      always_comb
      begin
        fl_set = '0;
        fl_set[FL_UV] = uv_trip;
        fl_set[FL_OC] = oc_trip;
        fl_set[FL_OT] = ot_trip;
        fl_set[FL_DIE] = tsd_set;
      end

      // Hardware set wins over the end-of-frame clear
      always_ff @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
          fl_q <= '0;
        else
        begin
          fl_q <= (fl_q & {FL_W{~frame_clr}}) | fl_set;
        end
      end

      always_ff @(posedge mclk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          pg_q[c] <= 1'b0;
          switch_off[c] <= 1'b1;
          restart_seq[c] <= 1'b0;
        end
        else
        begin
          // Outputs drop with the die shutdown, not a cycle after it
          pg_q[c] <= (st_q == CH_RUN) & pgd_done[c] & ~hic_go[c] & ~tsd_q;
          switch_off[c] <= (st_q != CH_RUN) | hic_go[c] | tsd_q;
          restart_seq[c] <= (st_q == CH_START);
        end
      end
    end
  endgenerate

  assign power_good_out = pg_q;

  // ==========================================================================
  // Fault frame serialiser
  logic [11:0] slot_cnt_q;
  logic [3:0] slot_q;
  logic frame_end;
  logic pg_all;
  logic confirmed;
  logic [FRAME_SLOTS-1:0] frame_bits;

  assign frame_end = frame_q && slot_q == 4'(FRAME_SLOTS - 1)
    && slot_cnt_q == 12'(SLOT_CYC - 1);
  // A channel held off by its enable never raises power good again
  assign pg_all = ~tsd_q & (&(pg_q | ~(sy_q.en & ctrl_q)));
  assign confirmed = (|trip) | tsd_set;
  assign frame_clr = frame_end & pg_all;
  assign frame_bits = {flags[1], flags[0], FAULT_ALERT_LVL};

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      frame_q <= 1'b0;
    else if (!frame_q && (confirmed || (|flags[0]) || (|flags[1])))
      frame_q <= 1'b1;
    else if (frame_clr)
      frame_q <= 1'b0;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      slot_cnt_q <= '0;
      slot_q <= '0;
    end
    else if (!frame_q || slot_cnt_q == 12'(SLOT_CYC - 1))
    begin
      slot_cnt_q <= '0;
      if (!frame_q || slot_q == 4'(FRAME_SLOTS - 1))
        slot_q <= '0;
      else
        slot_q <= slot_q + 4'h1;
    end
    else
      slot_cnt_q <= slot_cnt_q + 12'h1;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      fault_out <= FAULT_IDLE;
    else if (frame_q)
      fault_out <= frame_bits[slot_q];
    else
      fault_out <= FAULT_IDLE;
  end

endmodule : dcfs_supervisor

// >>> dv/dcfs_stage_model.sv
// Far side model: switching tick, soft start and power good delay
`timescale 1ns/1ps
module dcfs_stage_model #(
  parameter int TICK = 20,
  parameter int PGD = 30
) (
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [1:0] restart_seq, // Rerun power-up
  input wire logic [1:0] switch_off, // Switches off
  output logic sw_tick, // Cycle tick
  output logic [1:0] ss_begun, // Soft start begun
  output logic [1:0] pgd_done // Delay expired
);
  logic [7:0] t_q;
  logic [1:0] off_q;
  logic [7:0] d_q [2];
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst) t_q <= 8'h0;
    else t_q <= (t_q == 8'(TICK - 1)) ? 8'h0 : t_q + 8'h1;
  end
  assign sw_tick = (t_q == 8'(TICK - 1));
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst) off_q <= 2'h3;
    else off_q <= switch_off;
  end
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    // Two off cycles needed so a late switch_off edge cannot cancel soft start
    always_ff @(posedge mclk or posedge sys_rst)
    begin
      if (sys_rst) ss_begun[c] <= 1'b0;
      else if (restart_seq[c]) ss_begun[c] <= 1'b1;
      else if (switch_off[c] && off_q[c]) ss_begun[c] <= 1'b0;
    end
    always_ff @(posedge mclk or posedge sys_rst)
    begin
      if (sys_rst) d_q[c] <= 8'h0;
      else if (!ss_begun[c]) d_q[c] <= 8'h0;
      else if (d_q[c] != 8'(PGD)) d_q[c] <= d_q[c] + 8'h1;
    end
    assign pgd_done[c] = ss_begun[c] && (d_q[c] == 8'(PGD));
  end
endmodule : dcfs_stage_model

// >>> dv/dcfs_supervisor_assertions.sv
// Port level checker for the fault supervisor
`timescale 1ns/1ps
module dcfs_sva
  import dcfs_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Reset
  input wire dcfs_pins_t pins, // Pin levels
  input wire logic [1:0] pgd_done, // Delay expired
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic [1:0] power_good_out, // Power good
  input wire logic [1:0] switch_off, // Switches off
  input wire logic [1:0] restart_seq, // Restart pulse
  input wire logic pwm_hiz, // High impedance
  input wire logic fault_out // Fault frame
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ==========
  // Length of each high run on the fault line
  logic [11:0] hi_q;
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst) hi_q <= 12'h0;
    else hi_q <= fault_out ? hi_q + 12'h1 : 12'h0;
  end
  sequence die_hot_s;
    (pins.die_hot && pins.supply_ok && pins.en != 2'h0) [*6];
  endsequence
  sequence no_delay_s;
    !pgd_done[0] ##1 !pgd_done[0];
  endsequence
  // ==========
  // Assertions
  chk_pg_switch: assert property ((power_good_out & switch_off) == 2'h0)
    else $error("power good while switches off");
  chk_pg_delay: assert property (no_delay_s |-> !power_good_out[0])
    else $error("power good before delay expired");
  chk_restart_pulse: assert property (restart_seq[0] |=> !restart_seq[0])
    else $error("restart pulse too long");
  chk_die_trip: assert property (die_hot_s |-> pwm_hiz)
    else $error("die shutdown missed");
  chk_hiz_all_off: assert property (pwm_hiz |-> switch_off == 2'h3 && !power_good_out)
    else $error("channel active in die shutdown");
  chk_slot_width: assert property ($fell(fault_out) |-> hi_q % SLOT_CYC == 0)
    else $error("fault slot width wrong");
  chk_frame_start: assert property ($fell(power_good_out[0]) && pins.en[0]
    && $past(pins.en[0], 4) |-> ##[0:3] fault_out)
    else $error("fault frame did not start");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule : dcfs_sva
bind dcfs_supervisor dcfs_sva i_dcfs_sva (.mclk(mclk), .sys_rst(sys_rst), .pins(pins),
  .pgd_done(pgd_done), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .power_good_out(power_good_out), .switch_off(switch_off), .restart_seq(restart_seq),
  .pwm_hiz(pwm_hiz), .fault_out(fault_out));

// >>> dv/tb_dcfs_supervisor.sv
// Self-checking bench for the fault supervisor
`timescale 1ns/1ps
module tb_dcfs_supervisor;
  import dcfs_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  dcfs_pins_t pins;
  logic two_phase = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] power_good_out, switch_off, phase_cut, restart_seq, ss_begun, pgd_done;
  logic pwm_hiz, fault_out, sw_tick;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  dcfs_supervisor #(.HICCUP_CYC(50)) i_dcfs_supervisor (.mclk(mclk), .sys_rst(sys_rst),
    .pins(pins), .sw_tick(sw_tick), .two_phase(two_phase), .ss_begun(ss_begun),
    .pgd_done(pgd_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_good_out(power_good_out),
    .switch_off(switch_off), .phase_cut(phase_cut), .restart_seq(restart_seq),
    .pwm_hiz(pwm_hiz), .fault_out(fault_out));
  dcfs_stage_model i_dcfs_stage_model (.mclk(mclk), .sys_rst(sys_rst),
    .restart_seq(restart_seq), .switch_off(switch_off), .sw_tick(sw_tick),
    .ss_begun(ss_begun), .pgd_done(pgd_done));
  initial forever #5 mclk = ~mclk;
  // ==========
  // Tasks; outputs are read at the edge, before that edge's updates land
  task end_sim;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(posedge mclk);
  endtask : cy
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk("rdata", e, reg_rdata);
  endtask : rdc
  task automatic wv(ref logic [1:0] s, input logic [1:0] e, input int n, input string m);
    for (int i = 0; i < n && s !== e; i++) @(posedge mclk);
    chk(m, e, s);
  endtask : wv
  task automatic fr(input logic [8:0] e);
    logic [8:0] s;
    for (int i = 0; i < 4000 && fault_out !== 1'b1; i++) @(posedge mclk);
    cy(SLOT_CYC / 2);
    for (int i = 0; i < 9; i++)
    begin
      s[i] = fault_out;
      cy(SLOT_CYC);
    end
    chk("frame", e, s);
  endtask : fr
  task automatic qt(input int n);
    int z;
    z = 0;
    for (int i = 0; i < n && z < 3700; i++)
    begin
      @(posedge mclk);
      z = (fault_out === 1'b0) ? z + 1 : 0;
    end
    chk("quiet", 1, z >= 3700);
  endtask : qt
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  // ==========
  // Main sequence
  initial
  begin
    pins = '0;
    pins.supply_ok = 1'b1;
    pins.ot_cool = 2'h3;
    pins.die_cool = 1'b1;
    pins.ot_cfg = 2'h2;
    pins.track_n = 1'b1;
    cy(5);
    sys_rst <= 1'b0;
    cy(3);
    chk("sw_off", 3, switch_off);
    rdc(REG_CTRL, 32'h3);
    pins.en <= 2'h3;
    wv(power_good_out, 2'h3, 300, "pg_up");
    rdc(REG_STATUS, 32'h00044003);
    rdc(4'h8, 32'h0);
    wr(REG_STATUS, 32'hffffffff);
    rdc(REG_STATUS, 32'h00044003);
    wr(REG_CTRL, 32'h3);
    pins.uv[0] <= 1'b1;
    cy(100);
    pins.uv[0] <= 1'b0;
    cy(5);
    chk("uv_short", 3, power_good_out);
    pins.uv[0] <= 1'b1;
    cy(160);
    chk("uv_pg", 2, power_good_out);
    chk("uv_off", 1, switch_off);
    pins.uv[0] <= 1'b0;
    wv(restart_seq, 2'h1, 100, "uv_restart");
    wv(power_good_out, 2'h3, 100, "uv_back");
    fr(9'h003);
    qt(3800);
    pins.oc[1] <= 1'b1;
    wv(phase_cut, 2'h2, 25, "cut");
    cy(120);
    chk("oc_early", 3, power_good_out);
    cy(100);
    chk("oc_trip", 1, power_good_out);
    pins.oc[1] <= 1'b0;
    fr(9'h041);
    qt(3800);
    two_phase <= 1'b1;
    pins.oc[0] <= 1'b1;
    cy(230);
    chk("oc_shared", 3, power_good_out);
    pins.oc[0] <= 1'b0;
    cy(5);
    two_phase <= 1'b0;
    pins.ot_cool[0] <= 1'b0;
    pins.ot_pin[0] <= 1'b1;
    cy(6);
    chk("ot_trip", 2, power_good_out);
    pins.ot_pin[0] <= 1'b0;
    cy(200);
    chk("ot_hot", 2, power_good_out);
    pins.ot_cool[0] <= 1'b1;
    wv(power_good_out, 2'h3, 150, "ot_back");
    pins.ot_pin[1] <= 1'b1;
    cy(6);
    chk("ot_mode", 3, power_good_out);
    pins.ot_pin[1] <= 1'b0;
    pins.ot_ext[1] <= 1'b1;
    cy(6);
    chk("ot_ext", 1, power_good_out);
    pins.ot_ext[1] <= 1'b0;
    wv(power_good_out, 2'h3, 150, "ext_back");
    qt(12000);
    pins.en <= 2'h0;
    cy(5);
    pins.track_n <= 1'b0;
    cy(5);
    pins.en <= 2'h3;
    wv(power_good_out, 2'h3, 300, "trk_up");
    pins.ot_ext[1] <= 1'b1;
    cy(6);
    chk("trk_both", 0, power_good_out);
    pins.ot_ext[1] <= 1'b0;
    wv(power_good_out, 2'h3, 300, "trk_back");
    qt(12000);
    pins.en <= 2'h0;
    cy(5);
    pins.die_hot <= 1'b1;
    pins.die_cool <= 1'b0;
    cy(8);
    chk("die_idle", 0, pwm_hiz);
    pins.en <= 2'h3;
    cy(8);
    chk("die_hiz", 1, pwm_hiz);
    chk("die_off", 3, switch_off);
    pins.die_hot <= 1'b0;
    cy(3);
    pins.die_cool <= 1'b1;
    wv(power_good_out, 2'h3, 300, "die_back");
    chk("die_clr", 0, pwm_hiz);
    end_sim();
  end
endmodule : tb_dcfs_supervisor
